// ===== hw/tws_device.sv
`timescale 1ns/1ps
module tws_device
   import tws_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   tws_if.device             bus,
   input  wire logic [3:0]   node_addr,
   input  wire logic         address_strap_pin,
   input  wire logic [7:0]   rd_data,
   output logic [7:0]        reg_ptr,
   output logic [7:0]        wr_data,
   output logic              wr_valid,
   output logic [3:0]        wr_count,
   output logic              wr_done,
   output logic              rd_req
);
   typedef enum {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_IGNORE} tws_state_t;

   tws_state_t  state_reg;
   logic [1:0]  scl_sync_reg;
   logic [1:0]  sda_sync_reg;
   logic [1:0]  strap_sync_reg;
   logic [2:0]  scl_cnt_reg;
   logic [2:0]  sda_cnt_reg;
   logic        scl_f_reg;
   logic        sda_f_reg;
   logic [3:0]  bit_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic        ack_pend_reg;
   logic        drv_low_reg;
   logic        first_reg;
   logic [6:0]  own_addr;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [7:0]  rx_byte;

   assign own_addr  = {ADDR_FIXED, node_addr, strap_sync_reg[1]};
   assign scl_rise  = (scl_sync_reg[1] != scl_f_reg) && (scl_cnt_reg == 3'(SPIKE_CYC))
                      && scl_sync_reg[1];
   assign scl_fall  = (scl_sync_reg[1] != scl_f_reg) && (scl_cnt_reg == 3'(SPIKE_CYC))
                      && !scl_sync_reg[1];
   assign start_det = scl_f_reg && sda_f_reg && !sda_sync_reg[1]
                      && (sda_cnt_reg == 3'(SPIKE_CYC));
   assign stop_det  = scl_f_reg && !sda_f_reg && sda_sync_reg[1]
                      && (sda_cnt_reg == 3'(SPIKE_CYC));
   assign rx_byte   = {shift_reg[6:0], sda_f_reg};

   // Two-stage synchronisers
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         scl_sync_reg   <= 2'h3;
         sda_sync_reg   <= 2'h3;
         strap_sync_reg <= 2'h0;
      end
      else
      begin
         scl_sync_reg   <= {scl_sync_reg[0], bus.scl};
         sda_sync_reg   <= {sda_sync_reg[0], bus.sda};
         strap_sync_reg <= {strap_sync_reg[0], address_strap_pin};
      end

   // Spike filter: level must persist past spike window
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         scl_cnt_reg <= 3'h0;
         scl_f_reg   <= 1'b1;
      end
      else if (scl_sync_reg[1] == scl_f_reg)
         scl_cnt_reg <= 3'h0;
      else if (scl_cnt_reg == 3'(SPIKE_CYC))
      begin
         scl_f_reg   <= scl_sync_reg[1];
         scl_cnt_reg <= 3'h0;
      end
      else
         scl_cnt_reg <= scl_cnt_reg + 3'h1;

   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         sda_cnt_reg <= 3'h0;
         sda_f_reg   <= 1'b1;
      end
      else if (sda_sync_reg[1] == sda_f_reg)
         sda_cnt_reg <= 3'h0;
      else if (sda_cnt_reg == 3'(SPIKE_CYC))
      begin
         sda_f_reg   <= sda_sync_reg[1];
         sda_cnt_reg <= 3'h0;
      end
      else
         sda_cnt_reg <= sda_cnt_reg + 3'h1;

   // Framing and byte engine
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         state_reg    <= ST_IDLE;
         bit_reg      <= 4'h0;
         shift_reg    <= 8'h00;
         tx_reg       <= 8'h00;
         ack_pend_reg <= 1'b0;
         drv_low_reg  <= 1'b0;
         first_reg    <= 1'b0;
         reg_ptr      <= 8'h00;
         wr_data      <= 8'h00;
         wr_valid     <= 1'b0;
         wr_count     <= 4'h0;
         wr_done      <= 1'b0;
         rd_req       <= 1'b0;
      end
      else
      begin
         wr_valid <= 1'b0;
         wr_done  <= 1'b0;
         rd_req   <= 1'b0;
         if (start_det)
         begin
            state_reg   <= ST_ADDR;
            bit_reg     <= 4'h0;
            drv_low_reg <= 1'b0;
            wr_count    <= 4'h0;
         end
         else if (stop_det)
         begin
            if (state_reg == ST_WRITE && wr_count != 4'h0)
               wr_done <= 1'b1;
            state_reg   <= ST_IDLE;
            drv_low_reg <= 1'b0;
         end
         else if (state_reg != ST_IDLE && state_reg != ST_IGNORE)
         begin
            if (scl_rise && bit_reg < ACK_BIT)
            begin
               shift_reg <= rx_byte;
               bit_reg   <= bit_reg + 4'h1;
            end
            else if (scl_rise)
            begin
               if (state_reg == ST_READ && sda_f_reg)
                  state_reg <= ST_IGNORE;
               ack_pend_reg <= 1'b1;
            end
            if (scl_fall)
            begin
               // Drive changes after falling edge; a start or stop only clears it
               if (bit_reg == ACK_BIT && !ack_pend_reg)
               begin
                  ack_pend_reg <= 1'b0;
                  case (state_reg)
                     ST_ADDR:
                        if (shift_reg[7:1] == own_addr || shift_reg[7:1] == GENERAL_CALL)
                        begin
                           drv_low_reg <= 1'b1;
                           first_reg   <= 1'b1;
                           if (shift_reg[0])
                           begin
                              state_reg <= ST_READ;
                              rd_req    <= 1'b1;
                           end
                           else
                              state_reg <= ST_WRITE;
                        end
                        else
                           state_reg <= ST_IGNORE;
                     ST_WRITE:
                        begin
                           drv_low_reg <= (wr_count < 4'(MAX_BYTES));
                           if (first_reg)
                              reg_ptr <= shift_reg;
                           first_reg <= 1'b0;
                           wr_data   <= shift_reg;
                           wr_valid  <= 1'b1;
                           if (wr_count < 4'(MAX_BYTES))
                              wr_count <= wr_count + 4'h1;
                        end
                     default:
                        drv_low_reg <= 1'b0;
                  endcase
               end
               else if (ack_pend_reg)
               begin
                  ack_pend_reg <= 1'b0;
                  bit_reg      <= 4'h0;
                  if (state_reg == ST_READ)
                  begin
                     tx_reg      <= rd_data;
                     drv_low_reg <= !rd_data[BIT_MSB];
                     rd_req      <= !first_reg;
                     first_reg   <= 1'b0;
                  end
                  else
                     drv_low_reg <= 1'b0;
               end
               else if (state_reg == ST_READ && bit_reg < ACK_BIT)
                  drv_low_reg <= !tx_reg[BIT_MSB - bit_reg[2:0]];
            end
         end
      end

   assign bus.sda_dev_o  = 1'b0;
   assign bus.sda_dev_oe = drv_low_reg;
endmodule : tws_device

// ===== hw/tws_pkg.sv
package tws_pkg;
   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          SPIKE_NS       = 50;
   localparam int          SPIKE_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          BYTE_BITS      = 8;
   localparam int          MAX_BYTES      = 8;
   localparam logic [1:0]  ADDR_FIXED     = 2'h3;
   localparam logic [6:0]  GENERAL_CALL   = 7'h00;
   localparam logic [3:0]  NODE_RESET     = 4'h0;
   localparam int          SCL_HALF_CYC   = 4;
   localparam logic [2:0]  BIT_MSB        = 3'h7;
   localparam logic [3:0]  ACK_BIT        = 4'h8;
endpackage : tws_pkg

// ===== hw/tws_if.sv
`timescale 1ns/1ps
interface tws_if;
   logic scl_o;
   logic scl_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_mst_o;
   logic sda_mst_oe;
   wire  scl = scl_oe ? scl_o : 1'b1;
   wire  sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_mst_oe & ~sda_mst_o));
   modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport master (input scl, input sda, output scl_o, output scl_oe,
                   output sda_mst_o, output sda_mst_oe);
endinterface : tws_if

// ===== hw/tws_master.sv
`timescale 1ns/1ps
module tws_master
   import tws_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   tws_if.master             bus,
   input  wire logic         cmd_valid,
   input  wire logic         cmd_read,
   input  wire logic [6:0]   cmd_addr,
   input  wire logic [3:0]   cmd_len,
   input  wire logic [63:0]  cmd_wdata,
   output logic              cmd_ready,
   output logic              done,
   output logic              nack,
   output logic [63:0]       rdata
);
   typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} tws_mstate_t;

   tws_mstate_t state_reg;
   logic [2:0]  div_reg;
   logic [1:0]  ph_reg;
   logic [3:0]  bit_reg;
   logic [3:0]  byte_reg;
   logic [3:0]  len_reg;
   logic        rd_reg;
   logic [7:0]  sh_reg;
   logic [63:0] wbuf_reg;
   logic        sda_low_reg;
   logic        scl_low_reg;
   logic [1:0]  sda_sync_reg;
   logic        tick;

   assign tick = (div_reg == 3'(SCL_HALF_CYC - 1));

   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         sda_sync_reg <= 2'h3;
      else
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};

   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         div_reg <= 3'h0;
      else if (tick || state_reg == MS_IDLE)
         div_reg <= 3'h0;
      else
         div_reg <= div_reg + 3'h1;

   // Byte 0 is the address byte, then payload bytes
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         state_reg   <= MS_IDLE;
         ph_reg      <= 2'h0;
         bit_reg     <= 4'h0;
         byte_reg    <= 4'h0;
         len_reg     <= 4'h0;
         rd_reg      <= 1'b0;
         sh_reg      <= 8'h00;
         wbuf_reg    <= 64'h0;
         sda_low_reg <= 1'b0;
         scl_low_reg <= 1'b0;
         cmd_ready   <= 1'b1;
         done        <= 1'b0;
         nack        <= 1'b0;
         rdata       <= 64'h0;
      end
      else
      begin
         done <= 1'b0;
         case (state_reg)
            MS_IDLE:
               if (cmd_valid)
               begin
                  cmd_ready   <= 1'b0;
                  nack        <= 1'b0;
                  rd_reg      <= cmd_read;
                  len_reg     <= (cmd_len > 4'(MAX_BYTES)) ? 4'(MAX_BYTES) : cmd_len;
                  wbuf_reg    <= cmd_wdata;
                  sh_reg      <= {cmd_addr, cmd_read};
                  byte_reg    <= 4'h0;
                  bit_reg     <= 4'h0;
                  ph_reg      <= 2'h0;
                  sda_low_reg <= 1'b1;
                  state_reg   <= MS_START;
               end
            MS_START:
               if (tick)
               begin
                  scl_low_reg <= 1'b1;
                  state_reg   <= MS_BIT;
               end
            MS_BIT:
               if (tick)
               begin
                  ph_reg <= ph_reg + 2'h1;
                  case (ph_reg)
                     2'h0:
                        begin // Clock low: set data
                           if (bit_reg < ACK_BIT)
                              sda_low_reg <= (rd_reg && byte_reg != 4'h0) ? 1'b0
                                             : !sh_reg[BIT_MSB];
                           else if (rd_reg && byte_reg != 4'h0)
                              sda_low_reg <= (byte_reg != len_reg);
                           else
                              sda_low_reg <= 1'b0;
                        end
                     2'h1:
                        scl_low_reg <= 1'b0;
                     2'h2:
                        begin // Clock high: sample
                           if (bit_reg < ACK_BIT)
                              sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                           else if (!(rd_reg && byte_reg != 4'h0) && sda_sync_reg[1])
                              nack <= 1'b1;
                        end
                     default:
                        begin
                           scl_low_reg <= 1'b1;
                           if (bit_reg < ACK_BIT)
                              bit_reg <= bit_reg + 4'h1;
                           else
                           begin
                              bit_reg <= 4'h0;
                              if (rd_reg && byte_reg != 4'h0)
                                 rdata <= {rdata[55:0], sh_reg};
                              if (byte_reg == len_reg || nack)
                              begin
                                 // Data pulled one tick later, never with clock fall
                                 state_reg   <= MS_STOP;
                              end
                              else
                              begin
                                 sh_reg   <= wbuf_reg[63:56];
                                 wbuf_reg <= {wbuf_reg[55:0], 8'h00};
                              end
                              byte_reg <= byte_reg + 4'h1;
                           end
                        end
                  endcase
               end
            MS_STOP:
               if (tick)
               begin
                  ph_reg <= ph_reg + 2'h1;
                  if (ph_reg == 2'h0)
                     sda_low_reg <= 1'b1;
                  else if (ph_reg == 2'h1)
                     scl_low_reg <= 1'b0;
                  else if (ph_reg == 2'h2)
                     sda_low_reg <= 1'b0;
                  else
                  begin
                     state_reg <= MS_IDLE;
                     cmd_ready <= 1'b1;
                     done      <= 1'b1;
                  end
               end
            default:
               state_reg <= MS_IDLE;
         endcase
      end

   assign bus.scl_o      = 1'b0;
   assign bus.scl_oe     = scl_low_reg;
   assign bus.sda_mst_o  = 1'b0;
   assign bus.sda_mst_oe = sda_low_reg;
endmodule : tws_master

// ===== tb/tws_asserts.sv
`timescale 1ns/1ps
module tws_asserts
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic sda_mst_o,
   input wire logic sda_mst_oe
);
   logic [3:0] run_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Clock rises seen while the device keeps pulling data low
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         run_reg <= 4'h0;
      else if (!sda_dev_oe)
         run_reg <= 4'h0;
      else if ($rose(scl))
         run_reg <= run_reg + 4'h1;
   end

   a_dev_pull_low: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("device drove data high");
   a_mst_clock_low: assert property (scl_oe |-> !scl_o)
      else $error("clock driven high");
   a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device changed data while clock high");
   a_sample_stable: assert property ($rose(scl) |-> $stable(sda))
      else $error("data moved at clock rise");
   a_high_dev_hold: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
      else $error("device made a start or stop");
   a_byte_bit_count: assert property (run_reg <= 4'h9)
      else $error("device held data longer than one byte and ack");
   a_start_released: assert property ($fell(sda) && scl && $past(scl) |-> !sda_dev_oe)
      else $error("device pulling data at start");
   a_stop_released: assert property ($rose(sda) && scl && $past(scl) |=> !sda_dev_oe [*8])
      else $error("device pulled data after stop");
endmodule : tws_asserts

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic nk; logic [63:0] rd; logic [63:0] mk;} tws_exp_t;

   logic        clk;
   logic        nrst;
   logic [3:0]  node_addr;
   logic        strap;
   logic [7:0]  rd_data;
   logic [7:0]  reg_ptr;
   logic [7:0]  wr_data;
   logic        wr_valid;
   logic [3:0]  wr_count;
   logic        wr_done;
   logic        rd_req;
   logic        cmd_valid;
   logic        cmd_read;
   logic [6:0]  cmd_addr;
   logic [3:0]  cmd_len;
   logic [63:0] cmd_wdata;
   logic        cmd_ready;
   logic        done;
   logic        nack;
   logic [63:0] rdata;
   int          n_fail;
   int          checks_done;
   int          cyc;
   int          n_rdreq;
   logic [7:0]  wr_q[$];
   logic [11:0] wd_q[$];
   tws_exp_t    dn_q[$];
   tws_exp_t    ex;
   logic [63:0] d;
   logic [3:0]  nd;
   logic [7:0]  r;

   tws_if bus ();
   tws_device u_tws_device (.clk(clk), .nrst(nrst), .bus(bus.device), .node_addr(node_addr),
      .address_strap_pin(strap), .rd_data(rd_data), .reg_ptr(reg_ptr), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_count(wr_count), .wr_done(wr_done), .rd_req(rd_req));
   tws_master u_tws_master (.clk(clk), .nrst(nrst), .bus(bus.master), .cmd_valid(cmd_valid),
      .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .done(done), .nack(nack), .rdata(rdata));
   tws_asserts u_tws_asserts (.clk(clk), .nrst(nrst), .scl(bus.scl), .sda(bus.sda),
      .scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .sda_dev_o(bus.sda_dev_o),
      .sda_dev_oe(bus.sda_dev_oe), .sda_mst_o(bus.sda_mst_o), .sda_mst_oe(bus.sda_mst_oe));

   initial clk = 1'h0;
   always #10 clk = ~clk;

   task automatic chk(input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (e !== g)
      begin
         n_fail++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   // Notes expectations, issues one command, waits for its end
   task automatic run_cmd(input logic rd, input logic [6:0] a, input logic [3:0] n,
                          input logic [63:0] w, input logic hit, input logic [63:0] er,
                          input logic [63:0] mk);
      int       k;
      tws_exp_t e;
      if (!rd && hit)
      begin
         for (k = 0; k < n; k++)
            wr_q.push_back(w[63-8*k -: 8]);
         wd_q.push_back({n, w[63:56]});
      end
      e.nk = ~hit;
      e.rd = er;
      e.mk = mk;
      dn_q.push_back(e);
      cmd_read <= rd;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_wdata <= w;
      cmd_valid <= 1'h1;
      @(posedge clk);
      while (cmd_ready !== 1'h1)
         @(posedge clk);
      cmd_valid <= 1'h0;
      @(posedge clk);
      while (done !== 1'h1)
         @(posedge clk);
   endtask : run_cmd

   // Result watcher
   always @(posedge clk)
   begin
      if (rd_req === 1'h1)
         n_rdreq++;
      if (wr_valid === 1'h1)
         chk(wr_q.size() > 0 ? {56'h0, wr_q.pop_front()} : '1, {56'h0, wr_data});
      if (wr_done === 1'h1)
         chk(wd_q.size() > 0 ? {52'h0, wd_q.pop_front()} : '1, {52'h0, wr_count, reg_ptr});
      if (done === 1'h1)
      begin
         ex = dn_q.size() > 0 ? dn_q.pop_front() : '1;
         chk({63'h0, ex.nk}, {63'h0, nack});
         chk(ex.rd & ex.mk, rdata & ex.mk);
      end
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_fail++;
         complete_run();
      end
   end

   initial
   begin
      nrst = 1'h0;
      cmd_valid = 1'h0;
      cmd_read = 1'h0;
      cmd_addr = 7'h00;
      cmd_len = 4'h0;
      cmd_wdata = 64'h0;
      node_addr = 4'h0;
      strap = 1'h0;
      rd_data = 8'h00;
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      n_rdreq = 0;
      void'($urandom(35));
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      d = {$urandom, $urandom};
      run_cmd(1'h0, 7'h60, 4'h8, d, 1'h1, 64'h0, 64'h0);
      $display("test write eight done");
      nd = 4'($urandom);
      node_addr <= nd;
      strap <= 1'h1;
      run_cmd(1'h0, {2'h3, nd, 1'h1}, 4'h2, d, 1'h1, 64'h0, 64'h0);
      $display("test node and strap done");
      run_cmd(1'h0, 7'h00, 4'h2, ~d, 1'h1, 64'h0, 64'h0);
      $display("test general call done");
      run_cmd(1'h0, {2'h3, ~nd, 1'h0}, 4'h2, d, 1'h0, 64'h0, 64'h0);
      $display("test foreign address done");
      r = 8'($urandom);
      rd_data <= r;
      run_cmd(1'h0, {2'h3, nd, 1'h1}, 4'h1, d, 1'h1, 64'h0, 64'h0);
      run_cmd(1'h1, {2'h3, nd, 1'h1}, 4'h8, d, 1'h1, {8{r}}, 64'hFFFFFFFFFFFFFFFF);
      chk({56'h0, reg_ptr}, {56'h0, d[63:56]});
      chk(64'(n_rdreq), 64'h8);
      $display("test pointer and read done");
      repeat (10) @(posedge clk);
      chk(64'(wr_q.size() + wd_q.size() + dn_q.size()), 64'h0);
      complete_run();
   end
endmodule : tb_top
